// File: logic/dvo_pkg.sv
// package: constants, field layouts and carrier types of the pixel formatter
// assumes: shared by the formatter top, its checker and its bench
package dvo_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned COLOR_W  = 8;
  localparam int unsigned PIX_W    = 24;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned CTRL_W   = 4;
  localparam int unsigned STAT_W   = 4;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;

  // ==========================================================================
  // control register fields and reset value
  localparam int unsigned CTRL_PIXEL_PER_CLOCK_SELECT_BIT = 0;
  localparam int unsigned CTRL_EDGE_BIT = 1;
  localparam int unsigned CTRL_PD_BIT   = 2;
  localparam int unsigned CTRL_PDO_BIT  = 3;
  localparam logic [3:0]  CTRL_RST      = 4'hE;

  // ==========================================================================
  // status register fields
  localparam int unsigned STAT_LINK_BIT = 0;
  localparam int unsigned STAT_DE_BIT   = 1;
  localparam int unsigned STAT_PIXEL_PER_CLOCK_SELECT_BIT = 2;
  localparam int unsigned STAT_PD_BIT   = 3;
  localparam logic [3:0]  STAT_RST      = 4'h0;

  // ==========================================================================
  // bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  // ==========================================================================
  // colour lanes on a 24-bit pixel bus
  localparam int unsigned BLUE_LSB  = 0;
  localparam int unsigned GREEN_LSB = 8;
  localparam int unsigned RED_LSB   = 16;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] ctl;
  } dvo_chan_s;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dvo_rgb_s;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic active_video_flag;
    logic control_bit_two;
    logic control_bit_three;
  } dvo_ctl_out_s;

  typedef enum logic [0:0] {
    PH_EVEN = 1'b0,
    PH_ODD  = 1'b1
  } dvo_phase_e;

endpackage

// File: logic/dvo_sync.sv
// two-flop level synchroniser, any width
// assumes: bits are quasi-static levels, each crossing on its own
`timescale 1ns/100ps
module dvo_sync #(
  parameter int unsigned     WIDTH = 1,
  parameter logic [WIDTH-1:0] RST  = '0
) (
  // destination clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      sync_r <= RST;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

// File: logic/dvo_rst_sync.sv
// reset synchroniser: asserts at once, releases on the second clock edge
// assumes: arst_n is the bus-domain asynchronous reset
`timescale 1ns/100ps
module dvo_rst_sync (
  // clock and asynchronous reset
  input  wire logic clk,
  input  wire logic arst_n,
  // synchronised reset
  output logic      rst_n
);

  logic [1:0] shift_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 2'h0;
    end else begin
      shift_r <= {shift_r[0], 1'b1};
    end
  end

  assign rst_n = shift_r[1];

endmodule

// File: logic/dvo_fmt.sv
// pixel output formatter of a video link receiver, with ahb-lite control
// assumes: decoded channels arrive on link_clk; bus on hclk; pins tri-stated
// by the pad ring from the *_oe outputs
//
// What this block does
// [R1] power-down low: all outputs off, inputs other than power-down ignored
// [R2] power-down defaults high, meaning normal operation
// [R3] drive-off low: outputs off except link flag and control bit one
// [R4] drive-off defaults high, output drivers on
// [R5] two-pixel mode: even and odd pixel output together each clock
// [R6] one-pixel mode: pixels sequentially on even bus, even first
// [R7] pixel index restarts at zero each line; zero is even
// [R8] one-pixel mode: odd bus held low
// [R9] even bus: blue 7:0, green 15:8, red 23:16, lsb lowest
// [R10] odd bus uses the same colour layout
// [R11] two-pixel mode: even bus carries only even pixels
// [R12] pixel outputs change synchronously with the output pixel clock
// [R13] channel zero: blue when active, syncs in blanking
// [R14] active video flag high in active display, low in blanking
// [R15] channel one: green when active, control bit one in blanking
// [R16] channel two: red when active, control bits two, three in blanking
// [R17] edge select high: latch on rising edge; low: falling edge
// [R18] output clock at pixel rate, half rate in two-pixel mode
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module dvo_fmt (
  // bus clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // decoded link, on the link clock
  input  wire logic                 link_clk,
  input  dvo_pkg::dvo_chan_s        chan_zero,
  input  dvo_pkg::dvo_chan_s        chan_one,
  input  dvo_pkg::dvo_chan_s        chan_two,
  input  wire logic                 dec_active,
  input  wire logic                 dec_link_up,
  // panel side
  output logic                      output_pixel_clock,
  output logic                      output_pixel_clock_oe,
  output logic      [23:0]          even_pixel_bus,
  output logic                      even_pixel_bus_oe,
  output logic      [23:0]          odd_pixel_bus,
  output logic                      odd_pixel_bus_oe,
  output dvo_pkg::dvo_ctl_out_s     ctl_out,
  output logic                      ctl_out_oe,
  output logic                      control_bit_one,
  output logic                      control_bit_one_oe,
  output logic                      link_active_flag,
  output logic                      link_active_flag_oe
);

  // ==========================================================================
  // bus side
  logic [dvo_pkg::CTRL_W-1:0] ctrl_r;
  logic [dvo_pkg::CTRL_W-1:0] ctrl_nxt;
  logic [dvo_pkg::STAT_W-1:0] stat_h;
  logic [dvo_pkg::ADDR_W-1:0] addr_r;
  logic                       wr_pend_r;
  logic                       take;
  logic [31:0]                hrdata_r;
  logic [31:0]                rd_val;

  assign take      = hsel & hready & (htrans == dvo_pkg::HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp     = dvo_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= '0;
    end else begin
      wr_pend_r <= take & hwrite;
      if (take) begin
        addr_r <= haddr[dvo_pkg::ADDR_W-1:0];
      end
    end
  end

  // while powered down only the power-down bit accepts a write
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_pend_r && addr_r == dvo_pkg::CTRL_OFS) begin
      if (ctrl_r[dvo_pkg::CTRL_PD_BIT]) begin
        ctrl_nxt = hwdata[dvo_pkg::CTRL_W-1:0];
      end else begin
        ctrl_nxt[dvo_pkg::CTRL_PD_BIT] = hwdata[dvo_pkg::CTRL_PD_BIT]; // R1
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= dvo_pkg::CTRL_RST; // R2 R4
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // read data registered in the address phase, sees a write just before
  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[dvo_pkg::ADDR_W-1:0] == dvo_pkg::CTRL_OFS) begin
      rd_val[dvo_pkg::CTRL_W-1:0] = ctrl_nxt;
    end else if (haddr[dvo_pkg::ADDR_W-1:0] == dvo_pkg::STAT_OFS) begin
      rd_val[dvo_pkg::STAT_W-1:0] = stat_h;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata_r <= rd_val;
    end
  end

  // ==========================================================================
  // crossings
  logic                       link_rst_n;
  logic [dvo_pkg::CTRL_W-1:0] ctrl_l;
  logic [dvo_pkg::STAT_W-1:0] stat_l;
  logic                       pixel_per_clock_select_l;
  logic                       edge_l;
  logic                       pd_l;
  logic                       pdo_l;

  dvo_rst_sync u_rst (
    .clk    (link_clk),
    .arst_n (hresetn),
    .rst_n  (link_rst_n)
  );

  // control word crossing: the word stands still while a toggle request
  // crosses, so the link side never takes a half-changed set of mode bits
  logic [dvo_pkg::CTRL_W-1:0] xfer_word_r;
  logic [dvo_pkg::CTRL_W-1:0] ctrl_l_r;
  logic                       xfer_req_r;
  logic                       xfer_busy;
  logic                       req_l;
  logic                       ack_l_r;
  logic                       ack_h;

  assign xfer_busy = xfer_req_r ^ ack_h;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_word_r <= dvo_pkg::CTRL_RST;
      xfer_req_r  <= 1'b0;
    end else if (!xfer_busy && (xfer_word_r != ctrl_r)) begin
      xfer_word_r <= ctrl_r;
      xfer_req_r  <= ~xfer_req_r;
    end
  end

  dvo_sync #(
    .WIDTH (1),
    .RST   (1'b0)
  ) u_req_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (xfer_req_r),
    .q     (req_l)
  );

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_l_r  <= 1'b0;
      ctrl_l_r <= dvo_pkg::CTRL_RST;
    end else begin
      ack_l_r <= req_l;
      if (req_l != ack_l_r) begin
        ctrl_l_r <= xfer_word_r;
      end
    end
  end

  dvo_sync #(
    .WIDTH (1),
    .RST   (1'b0)
  ) u_ack_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (ack_l_r),
    .q     (ack_h)
  );

  assign ctrl_l = ctrl_l_r;

  dvo_sync #(
    .WIDTH (dvo_pkg::STAT_W),
    .RST   (dvo_pkg::STAT_RST)
  ) u_stat_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (stat_l),
    .q     (stat_h)
  );

  assign pixel_per_clock_select_l = ctrl_l[dvo_pkg::CTRL_PIXEL_PER_CLOCK_SELECT_BIT];
  assign edge_l = ctrl_l[dvo_pkg::CTRL_EDGE_BIT];
  assign pd_l   = ctrl_l[dvo_pkg::CTRL_PD_BIT];
  assign pdo_l  = ctrl_l[dvo_pkg::CTRL_PDO_BIT];

  // ==========================================================================
  // pixel slot tracking
  dvo_pkg::dvo_phase_e phase_r;
  dvo_pkg::dvo_phase_e slot;
  logic                de_d_r;
  logic                line_start;
  logic                emit;
  dvo_pkg::dvo_rgb_s   cur_pix;
  dvo_pkg::dvo_rgb_s   even_hold_r;

  assign line_start = dec_active & ~de_d_r;
  assign slot       = line_start ? dvo_pkg::PH_EVEN : phase_r; // R7
  assign emit       = ~pixel_per_clock_select_l | (slot == dvo_pkg::PH_ODD);

  // colours only during active display
  always_comb begin
    cur_pix = '0;
    if (dec_active) begin
      cur_pix.blue  = chan_zero.data; // R13
      cur_pix.green = chan_one.data;  // R15
      cur_pix.red   = chan_two.data;  // R16
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      de_d_r <= 1'b0;
    end else begin
      de_d_r <= pd_l & dec_active;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase_r <= dvo_pkg::PH_EVEN;
    end else if (!pd_l || !pixel_per_clock_select_l) begin
      phase_r <= dvo_pkg::PH_EVEN;
    end else if (slot == dvo_pkg::PH_EVEN) begin
      phase_r <= dvo_pkg::PH_ODD; // R18
    end else begin
      phase_r <= dvo_pkg::PH_EVEN;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      even_hold_r <= '0;
    end else if (!pd_l) begin
      even_hold_r <= '0;
    end else if (slot == dvo_pkg::PH_EVEN) begin
      even_hold_r <= cur_pix;
    end
  end

  // ==========================================================================
  // pixel buses
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      even_pixel_bus <= '0;
      odd_pixel_bus  <= '0;
    end else if (!pd_l) begin
      even_pixel_bus <= '0; // R1
      odd_pixel_bus  <= '0;
    end else if (!pixel_per_clock_select_l) begin
      even_pixel_bus <= cur_pix; // R6 R9
      odd_pixel_bus  <= '0;      // R8
    end else if (emit) begin
      even_pixel_bus <= even_hold_r; // R5 R11 R12
      odd_pixel_bus  <= cur_pix;     // R10
    end
  end

  // ==========================================================================
  // syncs and control bits
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ctl_out         <= '0;
      control_bit_one <= 1'b0;
    end else if (!pd_l) begin
      ctl_out         <= '0;
      control_bit_one <= 1'b0;
    end else if (emit) begin
      ctl_out.active_video_flag <= dec_active; // R14
      if (!dec_active) begin
        ctl_out.hsync             <= chan_zero.ctl[0]; // R13
        ctl_out.vsync             <= chan_zero.ctl[1];
        control_bit_one           <= chan_one.ctl[1];  // R15
        ctl_out.control_bit_two   <= chan_two.ctl[0];  // R16
        ctl_out.control_bit_three <= chan_two.ctl[1];
      end
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_active_flag <= 1'b0;
    end else begin
      link_active_flag <= pd_l & dec_link_up;
    end
  end

  // ==========================================================================
  // output enables
  logic pins_oe_r;
  logic kept_oe_r;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pins_oe_r <= 1'b0;
      kept_oe_r <= 1'b0;
    end else begin
      pins_oe_r <= pd_l & pdo_l; // R1 R3
      kept_oe_r <= pd_l;         // R3
    end
  end

  assign even_pixel_bus_oe     = pins_oe_r;
  assign odd_pixel_bus_oe      = pins_oe_r;
  assign ctl_out_oe            = pins_oe_r;
  assign output_pixel_clock_oe = pins_oe_r;
  assign control_bit_one_oe    = kept_oe_r;
  assign link_active_flag_oe   = kept_oe_r;

  // ==========================================================================
  // output pixel clock: data change lands mid-period of the chosen edge
  always_comb begin
    if (!pd_l) begin
      output_pixel_clock = 1'b0;
    end else if (!pixel_per_clock_select_l) begin
      output_pixel_clock = link_clk ^ edge_l; // R17 R18
    end else begin
      output_pixel_clock = (phase_r == dvo_pkg::PH_ODD) ^ ~edge_l; // R17
    end
  end

  // ==========================================================================
  // status back to the bus domain
  assign stat_l[dvo_pkg::STAT_LINK_BIT] = link_active_flag;
  assign stat_l[dvo_pkg::STAT_DE_BIT]   = ctl_out.active_video_flag;
  assign stat_l[dvo_pkg::STAT_PIXEL_PER_CLOCK_SELECT_BIT] = pixel_per_clock_select_l;
  assign stat_l[dvo_pkg::STAT_PD_BIT]   = pd_l;

endmodule

// File: bench/dvo_panel.sv
// panel model: latches both pixel buses on the chosen output clock edge
// assumes: fall high picks the falling edge; active flag qualifies data
`timescale 1ns/100ps
module dvo_panel (
  // clock and edge choice
  input  wire logic        pclk,
  input  wire logic        fall,
  // pixel side
  input  wire logic [23:0] even_in,
  input  wire logic [23:0] odd_in,
  input  wire logic        de_in,
  input  wire logic        oe_in,
  // latched pixels
  output logic      [23:0] even_q,
  output logic      [23:0] odd_q
);
  always @(pclk) begin
    if ((pclk ^ fall) && de_in && oe_in) begin
      even_q <= even_in;
      odd_q <= odd_in;
    end
  end
endmodule

// File: bench/dvo_fmt_checker.sv
// checker: bus and panel-side assertions of the pixel formatter
// assumes: bound to dvo_fmt; control is tracked from bus writes
`timescale 1ns/100ps
module dvo_fmt_checker (
  // bus
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  input  wire logic [31:0]   hrdata,
  input  wire logic          hreadyout,
  input  wire logic          hresp,
  // link
  input  wire logic          link_clk,
  input  dvo_pkg::dvo_chan_s chan_zero,
  input  dvo_pkg::dvo_chan_s chan_one,
  input  dvo_pkg::dvo_chan_s chan_two,
  input  wire logic          dec_active,
  // panel
  input  wire logic          output_pixel_clock,
  input  wire logic          output_pixel_clock_oe,
  input  wire logic [23:0]   even_pixel_bus,
  input  wire logic          even_pixel_bus_oe,
  input  wire logic [23:0]   odd_pixel_bus,
  input  wire logic          odd_pixel_bus_oe,
  input  dvo_pkg::dvo_ctl_out_s ctl_out,
  input  wire logic          ctl_out_oe,
  input  wire logic          control_bit_one,
  input  wire logic          control_bit_one_oe,
  input  wire logic          link_active_flag_oe
);
  // ==========
  // helpers
  logic [3:0]  sh_r;
  logic [3:0]  lc_r;
  logic [2:0]  cnt_r;
  logic [23:0] pix;
  logic        wr_r, pa_r, ph_r, tk, ok, output_drive_off_n, pd, sel, two;
  assign tk = hsel && hready && htrans == dvo_pkg::HTRANS_NONSEQ;
  assign ok = cnt_r == 3'h7;
  assign pix = {chan_two.data, chan_one.data, chan_zero.data};
  assign {output_drive_off_n, pd, sel, two} = lc_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
    end else begin
      wr_r <= tk && hwrite && haddr[11:0] == dvo_pkg::CTRL_OFS;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_r <= dvo_pkg::CTRL_RST;
    end else if (wr_r) begin
      sh_r <= sh_r[2] ? hwdata[3:0] : {sh_r[3], hwdata[2], sh_r[1:0]};
    end
  end
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      lc_r <= dvo_pkg::CTRL_RST;
      cnt_r <= 3'h0;
    end else begin
      lc_r <= sh_r;
      cnt_r <= (lc_r != sh_r) ? 3'h0 : (ok ? cnt_r : cnt_r + 3'h1);
    end
  end
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      pa_r <= 1'b0;
      ph_r <= 1'b0;
    end else begin
      pa_r <= dec_active;
      ph_r <= (dec_active && !pa_r) ? 1'b1 : !ph_r;
    end
  end
  // ==========
  // assertions
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && hresp == dvo_pkg::HRESP_OKAY) else $error("bus answer");
  a_ctrl_read: assert property (@(posedge hclk)
    disable iff (!hresetn)
    tk && !hwrite && haddr[11:0] == dvo_pkg::CTRL_OFS
    |=> hrdata == {28'h0, sh_r}) else $error("control readback");
  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    tk && !hwrite && haddr[11:3] != 9'h0 |=> hrdata == 32'h0)
    else $error("unmapped read");
  a_pd_all_off: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && !pd |-> !(output_pixel_clock_oe || even_pixel_bus_oe ||
    odd_pixel_bus_oe || ctl_out_oe || control_bit_one_oe ||
    link_active_flag_oe || output_pixel_clock) && even_pixel_bus == 24'h0)
    else $error("power down outputs");
  a_drive_off: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && pd && !output_drive_off_n |-> !(even_pixel_bus_oe || odd_pixel_bus_oe ||
    ctl_out_oe || output_pixel_clock_oe) && control_bit_one_oe &&
    link_active_flag_oe) else $error("drive off enables");
  a_drive_on: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && pd && output_drive_off_n |-> even_pixel_bus_oe && odd_pixel_bus_oe && ctl_out_oe
    && output_pixel_clock_oe && control_bit_one_oe && link_active_flag_oe)
    else $error("drive on enables");
  a_odd_low: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && pd && !two |-> odd_pixel_bus == 24'h0) else $error("odd bus");
  a_one_pix: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && pd && !two && dec_active |=> even_pixel_bus == $past(pix) &&
    ctl_out.active_video_flag) else $error("one pixel map");
  a_blank_ctl: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && pd && !two && !dec_active |=> even_pixel_bus == 24'h0 &&
    !ctl_out.active_video_flag && ctl_out.hsync == $past(chan_zero.ctl[0])
    && ctl_out.vsync == $past(chan_zero.ctl[1]) &&
    control_bit_one == $past(chan_one.ctl[1]) &&
    ctl_out.control_bit_two == $past(chan_two.ctl[0]) &&
    ctl_out.control_bit_three == $past(chan_two.ctl[1]))
    else $error("blank controls");
  a_two_pair: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && pd && two && ph_r && dec_active && pa_r |=>
    odd_pixel_bus == $past(pix) && even_pixel_bus == $past(pix, 2))
    else $error("pixel pair");
  a_clk_edge: assert property (@(negedge link_clk)
    disable iff (!hresetn)
    ok && pd && !two |-> output_pixel_clock == !sel) else $error("clock edge");
  a_half_rate: assert property (@(posedge link_clk)
    disable iff (!hresetn)
    ok && pd && two && dec_active && pa_r |->
    output_pixel_clock == (ph_r ~^ sel))
    else $error("half rate clock");
endmodule

// File: bench/dvo_fmt_bench.sv
// bench: drives the bus and decoded link, checks via panel model and reads
// assumes: package, design, panel model and checker compiled before this
`timescale 1ns/100ps
module dvo_fmt_bench;
  // ==========
  // signals
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        link_clk, dec_active, dec_link_up, fall, lk;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        output_pixel_clock, output_pixel_clock_oe, even_pixel_bus_oe;
  logic        odd_pixel_bus_oe, ctl_out_oe, control_bit_one;
  logic        control_bit_one_oe, link_active_flag, link_active_flag_oe;
  logic [23:0] even_pixel_bus, odd_pixel_bus, pe, po, last_px, prev_px;
  dvo_pkg::dvo_chan_s    chan_zero, chan_one, chan_two;
  dvo_pkg::dvo_ctl_out_s ctl_out;
  int          n_mismatch, n_compared;
  assign hready = hreadyout;
  assign hsize = 3'h2;
  dvo_fmt dut (.*);
  dvo_panel panel (.pclk(output_pixel_clock), .fall(fall),
    .even_in(even_pixel_bus), .odd_in(odd_pixel_bus),
    .de_in(ctl_out.active_video_flag),
    .oe_in(even_pixel_bus_oe && ctl_out_oe), .even_q(pe), .odd_q(po));
  // ==========
  // clocks and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #40 link_clk = ~link_clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
  // ==========
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= dvo_pkg::HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic line(input int n, input logic up);
    logic [29:0] r;
    for (int i = 0; i < n + 16; i++) begin
      r = 30'($urandom);
      @(posedge link_clk);
      {chan_two, chan_one, chan_zero} <= r;
      dec_active <= i >= 8 && i < n + 8;
      dec_link_up <= up;
      if (i >= 8 && i < n + 8) begin
        prev_px = last_px;
        last_px = {r[29:22], r[19:12], r[9:2]};
      end
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    {chan_two, chan_one, chan_zero} = 30'h0;
    dec_active = 1'b0;
    dec_link_up = 1'b0;
    fall = 1'b0;
    last_px = 24'h0;
    prev_px = 24'h0;
    n_mismatch = 0;
    n_compared = 0;
    rd = $urandom(11744);
    repeat (3) @(posedge link_clk);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, dvo_pkg::CTRL_OFS, 32'h0, rd);
    check(rd, 32'hE);
    bus(1'b0, 12'h008, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, dvo_pkg::STAT_OFS, 32'hF, rd);
    bus(1'b1, 12'h008, 32'hF, rd);
    bus(1'b0, dvo_pkg::CTRL_OFS, 32'h0, rd);
    check(rd, 32'hE);
    for (int m = 0; m < 4; m++) begin
      lk = 1'($urandom_range(1));
      bus(1'b1, dvo_pkg::CTRL_OFS, 32'hC | m, rd);
      fall = !m[1];
      line(4 + 2 * $urandom_range(6), lk);
      check(32'(pe), 32'(m[0] ? prev_px : last_px));
      check(32'(po), m[0] ? 32'(last_px) : 32'h0);
      bus(1'b0, dvo_pkg::STAT_OFS, 32'h0, rd);
      check(rd, {28'h0, 1'b1, m[0], 1'b0, lk});
    end
    bus(1'b1, dvo_pkg::CTRL_OFS, 32'h6, rd);
    line(4, 1'b1);
    check(32'({even_pixel_bus_oe, odd_pixel_bus_oe, ctl_out_oe,
      output_pixel_clock_oe, control_bit_one_oe, link_active_flag_oe}),
      32'h3);
    bus(1'b1, dvo_pkg::CTRL_OFS, 32'hA, rd);
    line(4, 1'b1);
    check(32'({even_pixel_bus_oe, odd_pixel_bus_oe, ctl_out_oe,
      output_pixel_clock_oe, control_bit_one_oe, link_active_flag_oe,
      even_pixel_bus}), 32'h0);
    bus(1'b1, dvo_pkg::CTRL_OFS, 32'hF, rd);
    bus(1'b0, dvo_pkg::CTRL_OFS, 32'h0, rd);
    check(rd, 32'hE);
    wrap_up;
  end
endmodule
bind dvo_fmt dvo_fmt_checker chk (.*);
